/* shared/b2_sd_consts.vh */
`ifndef B2_SD_CONSTS_VH
`define B2_SD_CONSTS_VH

// Register map, byte wide
`define ADDR_CTRL          16'h1103
`define ADDR_DPER_2        16'h113D
`define ADDR_DPER_1        16'h113E
`define ADDR_DPER_0        16'h113F
`define ADDR_DLIM_1        16'h1142
`define ADDR_DLIM_0        16'h1143
`define ADDR_CPER_2        16'h1144
`define ADDR_CPER_1        16'h1145
`define ADDR_CPER_0        16'h1146
`define ADDR_CLIM_1        16'h1147
`define ADDR_CLIM_0        16'h1148
`define ADDR_BURST         16'h1149
`define ADDR_SUBLEN        16'h114A
`define ADDR_STATUS        16'h114B

// Control register fields
`define CTRL_B1_TYPE       0
`define CTRL_B2_TYPE       1
`define CTRL_REI_TYPE      2
`define CTRL_STD_SEL       3
`define CTRL_DESCR_DIS     4
`define CTRL_SD_EN         5
`define CTRL_SF_EN         6
`define CTRL_RESET         8'h01
`define CTRL_WMASK         8'h7F

// Reset values
`define DLIM_RESET         16'hFFFF
`define CLIM_RESET         16'hFFFF
`define PER_RESET          24'h00_0000
`define BURST_RESET        8'hFF
`define SUBLEN_RESET       8'h08

// Frame and timing
`define B2_BYTES           3
`define FRAME_US           125
`define MS_US              1000

`endif

/* src/b2_error_tally.v */
`timescale 1ns/1ps
module b2_error_tally (
	// Clock
	input  wire       clk,
	input  wire       nrst,
	input  wire       ce,
	// Frame input
	input  wire       frame_valid,
	input  wire [23:0] b2_err_bits,
	input  wire       per_frame,
	// Tally out
	output reg        tally_valid_r,
	output reg  [4:0] tally_r
);
	`include "b2_sd_consts.vh"

	function [4:0] popcount;
		input [23:0] v;
		integer i;
		begin
			popcount = 5'h00;
			for (i = 0; i < 24; i = i + 1)
				popcount = popcount + {4'h0, v[i]};
		end
	endfunction

	always @(posedge clk) begin
		if (!nrst) begin
			tally_valid_r <= 1'b0;
			tally_r       <= 5'h00;
		end else if (ce) begin
			tally_valid_r <= frame_valid;
			if (frame_valid) begin
				if (per_frame)
					tally_r <= {4'h0, |b2_err_bits}; // R02 R04
				else
					tally_r <= popcount(b2_err_bits); // R01 R03
			end
		end
	end
endmodule

/* src/b2_sd_detector.v */
`timescale 1ns/1ps
// Overview of operation
// [R01] Control bit 1 low: tally each errored bit of the B2 bytes.
// [R02] Control bit 1 high: tally errored frames instead of bits.
// [R03] Per-bit mode can record up to 24 errors in one frame.
// [R04] Per-frame mode records exactly one error for any errored frame.
// [R05] Error counter advances by the errored bit count in per-bit mode.
// [R06] Tally mode applies to SD, SF criteria and the counter alike.
// [R07] Detected B2 errors drive the upstream line remote error indication.
// [R08] SD accumulates errors over a window equal to the declare period.
// [R09] Declare SD when window count reaches the declare threshold.
// [R10] While declared, clear SD when a clear period count is below threshold.
// [R11] Separate programmable declare and clear thresholds.
// [R12] Separate programmable declare and clear monitoring periods.
// [R13] Errors beyond the burst limit per sub-interval are discarded toward declare.
// [R14] Declare threshold is 16 bits over two byte registers, high first.
// [R15] Declare period is 24 bits over three byte registers, in 1 ms units.
// [R16] SD changes only while SD enable bit 5 is set, else held cleared.
// [R17] SD window evaluated and state updated once per frame.
`include "b2_sd_consts.vh"

module b2_sd_detector #(
	parameter CLK_HZ        = 20000000,
	parameter FRAMES_PER_MS = `MS_US / `FRAME_US
) (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	input  wire        ce,
	// Microprocessor port
	input  wire [15:0] addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata_r,
	// Receive frame side
	input  wire        frame_valid,
	input  wire [23:0] b2_err_bits,
	// Results
	output reg  [31:0] b2_err_count_r,
	output reg  [4:0]  rei_count_r,
	output reg         rei_valid_r,
	output wire [4:0]  sf_tally,
	output wire        sf_tally_valid,
	output reg         sd_defect_r,
	output wire        sf_enable,
	output wire        framing_standard_select,
	output wire        descramble_disable
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg [7:0]  ctrl_r;
	reg [15:0] degrade_declare_limit_r;
	reg [23:0] degrade_declare_period_r;
	reg [15:0] clear_limit_r;
	reg [23:0] clear_period_r;
	reg [7:0]  burst_limit_r;
	reg [7:0]  sub_len_r;

	wire per_frame = ctrl_r[`CTRL_B2_TYPE];
	wire sd_en     = ctrl_r[`CTRL_SD_EN];
	assign sf_enable               = ctrl_r[`CTRL_SF_EN];
	assign framing_standard_select = ctrl_r[`CTRL_STD_SEL];
	assign descramble_disable      = ctrl_r[`CTRL_DESCR_DIS];

	// Multi-byte values are plain bytes with no shadow latch; write them
	// while the detector is disabled or a torn value may be used for a frame
	always @(posedge clk) begin
		if (!nrst) begin
			ctrl_r                   <= `CTRL_RESET;
			degrade_declare_limit_r  <= `DLIM_RESET;
			degrade_declare_period_r <= `PER_RESET;
			clear_limit_r            <= `CLIM_RESET;
			clear_period_r           <= `PER_RESET;
			burst_limit_r            <= `BURST_RESET;
			sub_len_r                <= `SUBLEN_RESET;
		end else if (ce && wr) begin
			case (addr)
			`ADDR_CTRL:   ctrl_r <= wdata & `CTRL_WMASK;
			`ADDR_DLIM_1: degrade_declare_limit_r[15:8] <= wdata; // R14
			`ADDR_DLIM_0: degrade_declare_limit_r[7:0]  <= wdata; // R14
			`ADDR_DPER_2: degrade_declare_period_r[23:16] <= wdata; // R15
			`ADDR_DPER_1: degrade_declare_period_r[15:8]  <= wdata; // R15
			`ADDR_DPER_0: degrade_declare_period_r[7:0]   <= wdata; // R15
			`ADDR_CLIM_1: clear_limit_r[15:8] <= wdata; // R11
			`ADDR_CLIM_0: clear_limit_r[7:0]  <= wdata; // R11
			`ADDR_CPER_2: clear_period_r[23:16] <= wdata; // R12
			`ADDR_CPER_1: clear_period_r[15:8]  <= wdata; // R12
			`ADDR_CPER_0: clear_period_r[7:0]   <= wdata; // R12
			`ADDR_BURST:  burst_limit_r <= wdata;
			`ADDR_SUBLEN: sub_len_r <= wdata;
			default: ;
			endcase
		end
	end

	// Read data stands until the next read strobe
	always @(posedge clk) begin
		if (!nrst)
			rdata_r <= 8'h00;
		else if (ce && rd) begin
			case (addr)
			`ADDR_CTRL:   rdata_r <= ctrl_r;
			`ADDR_DLIM_1: rdata_r <= degrade_declare_limit_r[15:8];
			`ADDR_DLIM_0: rdata_r <= degrade_declare_limit_r[7:0];
			`ADDR_DPER_2: rdata_r <= degrade_declare_period_r[23:16];
			`ADDR_DPER_1: rdata_r <= degrade_declare_period_r[15:8];
			`ADDR_DPER_0: rdata_r <= degrade_declare_period_r[7:0];
			`ADDR_CLIM_1: rdata_r <= clear_limit_r[15:8];
			`ADDR_CLIM_0: rdata_r <= clear_limit_r[7:0];
			`ADDR_CPER_2: rdata_r <= clear_period_r[23:16];
			`ADDR_CPER_1: rdata_r <= clear_period_r[15:8];
			`ADDR_CPER_0: rdata_r <= clear_period_r[7:0];
			`ADDR_BURST:  rdata_r <= burst_limit_r;
			`ADDR_SUBLEN: rdata_r <= sub_len_r;
			`ADDR_STATUS: rdata_r <= {7'h00, sd_defect_r};
			default:      rdata_r <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-frame tally, one mode for every consumer
	wire       tally_valid;
	wire [4:0] tally;

	b2_error_tally u_tally (
		.clk           (clk),
		.nrst          (nrst),
		.ce            (ce),
		.frame_valid   (frame_valid),
		.b2_err_bits   (b2_err_bits),
		.per_frame     (per_frame),
		.tally_valid_r (tally_valid),
		.tally_r       (tally)
	);

	// One mode bit steers the counter, SD and SF alike
	assign sf_tally       = tally; // R06
	assign sf_tally_valid = tally_valid; // R06

	always @(posedge clk) begin
		if (!nrst) begin
			b2_err_count_r <= 32'h0000_0000;
			rei_count_r    <= 5'h00;
			rei_valid_r    <= 1'b0;
		end else if (ce) begin
			rei_valid_r <= tally_valid;
			if (tally_valid) begin
				b2_err_count_r <= b2_err_count_r + {27'h000_0000, tally}; // R05 R06
				rei_count_r    <= tally; // R07
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SD detector: fixed windows restarting each period, evaluated per frame
	// Cheaper than a true sliding sum; a burst straddling two windows may be missed
	// Period in frames; 1 ms units times frames per ms
	wire [31:0] dper_frames = degrade_declare_period_r * FRAMES_PER_MS;
	wire [31:0] cper_frames = clear_period_r * FRAMES_PER_MS;

	reg [31:0] win_frames_r;
	reg [15:0] win_count_r;
	reg [7:0]  sub_frames_r;
	reg [7:0]  sub_count_r;

	// Burst limit caps what one sub-interval may add toward declare
	// Lowering the limit mid sub-interval must not wrap the room to a huge value
	wire        sub_full  = sub_count_r >= burst_limit_r;
	wire [8:0]  sub_room  = sub_full ? 9'h000 : ({1'b0, burst_limit_r} - {1'b0, sub_count_r});
	wire [4:0]  capped    = ({4'h0, tally} > sub_room) ? sub_room[4:0] : tally;
	wire [4:0]  add_val   = sd_defect_r ? tally : capped; // R13
	wire [16:0] sum       = {1'b0, win_count_r} + {12'h000, add_val};
	// Saturate so a long window cannot wrap back under the limit
	wire [15:0] new_count = sum[16] ? 16'hFFFF : sum[15:0];
	wire [31:0] period    = sd_defect_r ? cper_frames : dper_frames; // R12
	wire        win_end   = (win_frames_r + 32'h0000_0001) >= period;
	wire        sub_end   = (sub_frames_r + 8'h01) >= sub_len_r;

	always @(posedge clk) begin
		if (!nrst) begin
			sd_defect_r  <= 1'b0;
			win_frames_r <= 32'h0000_0000;
			win_count_r  <= 16'h0000;
			sub_frames_r <= 8'h00;
			sub_count_r  <= 8'h00;
		end else if (ce) begin
			if (!sd_en) begin
				sd_defect_r  <= 1'b0; // R16
				win_frames_r <= 32'h0000_0000;
				win_count_r  <= 16'h0000;
				sub_frames_r <= 8'h00;
				sub_count_r  <= 8'h00;
			end else if (tally_valid) begin // R17
				if (sub_end) begin
					sub_frames_r <= 8'h00;
					sub_count_r  <= 8'h00;
				end else begin
					sub_frames_r <= sub_frames_r + 8'h01;
					sub_count_r  <= sub_count_r + {3'h0, capped};
				end
				// Declare may fire mid-window; clear waits for a full clear period
				if (!sd_defect_r && new_count >= degrade_declare_limit_r) begin
					sd_defect_r  <= 1'b1; // R09 R11
					win_frames_r <= 32'h0000_0000;
					win_count_r  <= 16'h0000;
				end else if (win_end) begin // R08
					if (sd_defect_r && new_count < clear_limit_r)
						sd_defect_r <= 1'b0; // R10 R11
					win_frames_r <= 32'h0000_0000;
					win_count_r  <= 16'h0000;
				end else begin
					win_frames_r <= win_frames_r + 32'h0000_0001;
					win_count_r  <= new_count;
				end
			end
		end
	end
endmodule

/* testbench/b2_frame_source.sv */
`timescale 1ns/1ps
module b2_frame_source (
	// Clock
	input  wire        clk,
	// Frame side
	output reg         frame_valid,
	output reg  [23:0] b2_err_bits
);
	initial begin
		frame_valid = 1'b0;
		b2_err_bits = 24'h00_0000;
	end
	// Bits mean nothing off the pulse; inverted so stale use shows
	task send(input [23:0] e);
		begin
			@(negedge clk);
			frame_valid = 1'b1;
			b2_err_bits = e;
			@(negedge clk);
			frame_valid = 1'b0;
			b2_err_bits = ~e;
		end
	endtask
endmodule

/* testbench/b2_sd_props.sv */
`timescale 1ns/1ps
module b2_sd_props (
	// Clock
	input wire        clk,
	input wire        nrst,
	input wire        ce,
	// Register port
	input wire [15:0] addr,
	input wire [7:0]  wdata,
	input wire        wr,
	// Frames and results
	input wire        frame_valid,
	input wire [23:0] b2_err_bits,
	input wire [31:0] b2_err_count_r,
	input wire [4:0]  rei_count_r,
	input wire        rei_valid_r,
	input wire [4:0]  sf_tally,
	input wire        sf_tally_valid,
	input wire        sd_defect_r
);
	// Shadow of the control byte, rebuilt from the write strobes
	reg  [7:0] ctrl_r;
	wire       sd_en = ctrl_r[5];
	always @(posedge clk) begin
		if (!nrst)
			ctrl_r <= 8'h01;
		else if (ce && wr && addr == 16'h1103)
			ctrl_r <= wdata;
	end
	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rei_done;
		sf_tally_valid ##1 (rei_valid_r && rei_count_r == $past(sf_tally));
	endsequence
	a_bit_tally: assert property (ce && frame_valid && !ctrl_r[1] |=>
		sf_tally_valid && sf_tally == $countones($past(b2_err_bits))) else $error("per-bit tally wrong");
	a_frame_tally: assert property (ce && frame_valid && ctrl_r[1] |=>
		sf_tally == {4'h0, $past(b2_err_bits) != 24'h00_0000}) else $error("per-frame tally wrong");
	a_count_step: assert property (sf_tally_valid |=>
		b2_err_count_r == $past(b2_err_count_r) + $past(sf_tally)) else $error("counter step wrong");
	a_count_hold: assert property (!sf_tally_valid |=> $stable(b2_err_count_r))
		else $error("counter moved without tally");
	a_rei_follow: assert property (sf_tally_valid |-> s_rei_done)
		else $error("remote error report missing");
	a_sd_off: assert property (!sd_en |=> !sd_defect_r)
		else $error("degrade set while disabled");
	a_sd_frame_only: assert property (!$stable(sd_defect_r) |->
		$past(frame_valid, 2) || !sd_en || !$past(sd_en)) else $error("degrade moved off frame");
	a_sd_cause: assert property ($rose(sd_defect_r) |->
		$past(sf_tally_valid) && $past(sf_tally) != 5'h00) else $error("degrade without errors");
	a_ce_freeze: assert property (!ce |=>
		$stable(b2_err_count_r) && $stable(sd_defect_r) && $stable(sf_tally_valid)) else $error("state moved while frozen");
endmodule

bind b2_sd_detector b2_sd_props i_props (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
	.wr(wr), .frame_valid(frame_valid), .b2_err_bits(b2_err_bits), .b2_err_count_r(b2_err_count_r),
	.rei_count_r(rei_count_r), .rei_valid_r(rei_valid_r), .sf_tally(sf_tally),
	.sf_tally_valid(sf_tally_valid), .sd_defect_r(sd_defect_r));

/* testbench/line_bip_error_tally_sd_detector_bench.sv */
`timescale 1ns/1ps
module line_bip_error_tally_sd_detector_bench;
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg  [15:0] addr = 16'h0000;
	reg  [7:0]  wdata = 8'h00;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg         ce = 1'b1;
	wire        frame_valid;
	wire [23:0] b2_err_bits;
	wire [7:0]  rdata_r;
	wire [31:0] b2_err_count_r;
	wire        sd_defect_r;
	wire [2:0]  lv;
	integer     mismatches = 0;
	integer     checked = 0;
	integer     i;
	reg  [31:0] exp_cnt = 32'h0000_0000;
	reg         pf = 1'b0;
	always #25 clk = ~clk;
	b2_frame_source u_src (.clk(clk), .frame_valid(frame_valid), .b2_err_bits(b2_err_bits));
	b2_sd_detector i_dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_r(rdata_r), .frame_valid(frame_valid), .b2_err_bits(b2_err_bits),
		.b2_err_count_r(b2_err_count_r), .rei_count_r(), .rei_valid_r(), .sf_tally(), .sf_tally_valid(),
		.sd_defect_r(sd_defect_r), .sf_enable(lv[2]), .framing_standard_select(lv[1]),
		.descramble_disable(lv[0]));
	////////////////////////////////////////
	function [31:0] ones(input [23:0] v);
		integer k;
		begin
			ones = 0;
			for (k = 0; k < 24; k = k + 1)
				ones = ones + v[k];
		end
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	task wreg(input [15:0] a, input [7:0] d);
		begin
			@(negedge clk);
			addr = a;
			wdata = d;
			wr = 1'b1;
			@(negedge clk);
			wr = 1'b0;
		end
	endtask
	task rreg(input [15:0] a, input [7:0] d);
		begin
			@(negedge clk);
			addr = a;
			rd = 1'b1;
			@(negedge clk);
			rd = 1'b0;
			check(rdata_r, d);
		end
	endtask
	task frame(input [23:0] e);
		begin
			u_src.send(e);
			exp_cnt = exp_cnt + (pf ? (e != 24'h00_0000) : ones(e));
			@(negedge clk);
			check(b2_err_count_r, exp_cnt);
		end
	endtask
	task final_report;
		begin
			$display("Checks %0d, mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	////////////////////////////////////////
	initial begin
		i = $urandom(32'h2913597c);
		repeat (16) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		rreg(16'h1103, 8'h01);
		rreg(16'h1143, 8'hFF);
		wreg(16'h1150, 8'h55);
		rreg(16'h1150, 8'h00);
		wreg(16'h1103, 8'hFF);
		rreg(16'h1103, 8'h7F);
		check(lv, 3'b111);
		wreg(16'h1142, 8'h12);
		rreg(16'h1142, 8'h12);
		for (i = 0; i < 40; i = i + 1) begin
			if (i % 20 == 0) begin
				pf = (i >= 20);
				wreg(16'h1103, {6'h00, pf, 1'b0});
			end
			frame(i % 20 == 0 ? 24'hFF_FFFF : i % 20 == 1 ? 24'h80_0000 : $urandom);
		end
		ce = 1'b0;
		u_src.send(24'hFF_FFFF);
		ce = 1'b1;
		@(negedge clk);
		check(b2_err_count_r, exp_cnt);
		pf = 1'b0;
		wreg(16'h1149, 8'h04);
		wreg(16'h114A, 8'h01);
		wreg(16'h1142, 8'h00);
		wreg(16'h1143, 8'h05);
		wreg(16'h1103, 8'h20);
		frame(24'hFF_FFFF);
		check(sd_defect_r, 0);
		wreg(16'h1143, 8'h04);
		frame(24'hFF_FFFF);
		check(sd_defect_r, 1);
		wreg(16'h1147, 8'h00);
		wreg(16'h1148, 8'h00);
		frame(24'h00_0000);
		check(sd_defect_r, 1);
		wreg(16'h1148, 8'h01);
		frame(24'h00_0000);
		check(sd_defect_r, 0);
		frame(24'hFF_FFFF);
		wreg(16'h1103, 8'h00);
		@(negedge clk);
		check(sd_defect_r, 0);
		wreg(16'h1149, 8'hFF);
		wreg(16'h1143, 8'h30);
		wreg(16'h1103, 8'h20);
		frame(24'hFF_FFFF);
		frame(24'hFF_FFFF);
		check(sd_defect_r, 0);
		wreg(16'h113F, 8'h01);
		wreg(16'h1103, 8'h00);
		wreg(16'h1103, 8'h20);
		frame(24'hFF_FFFF);
		frame(24'hFF_FFFF);
		check(sd_defect_r, 1);
		wreg(16'h1103, 8'h00);
		wreg(16'h1149, 8'h04);
		wreg(16'h114A, 8'h02);
		wreg(16'h1143, 8'h09);
		wreg(16'h1103, 8'h20);
		for (i = 0; i < 4; i = i + 1)
			frame(24'hFF_FFFF);
		check(sd_defect_r, 0);
		frame(24'hFF_FFFF);
		check(sd_defect_r, 1);
		rreg(16'h114B, 8'h01);
		rreg(16'h1149, 8'h04);
		wreg(16'h1146, 8'h02);
		for (i = 0; i < 15; i = i + 1)
			frame(24'h00_0000);
		check(sd_defect_r, 1);
		frame(24'h00_0000);
		check(sd_defect_r, 0);
		rreg(16'h114B, 8'h00);
		rreg(16'h1146, 8'h02);
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches = mismatches + 1;
		final_report;
	end
endmodule
